// File: shared/difd_consts.svh
// Offsets, field positions, function codes and timing of the input decoder.
// Included by the package and by the decoder; holds definitions only.
`ifndef DIFD_CONSTS_SVH
`define DIFD_CONSTS_SVH

// Register byte offsets
`define DIFD_OFS_CODE0 8'h00
`define DIFD_OFS_CODE4 8'h10
`define DIFD_OFS_CFG 8'h14
`define DIFD_OFS_STAT 8'h18
`define DIFD_OFS_ADJ 8'h1c

// Config register bits
`define DIFD_CFG_PULSE_OUT 0
`define DIFD_CFG_DC_TIME_NZ 1
`define DIFD_CFG_DC_VOLT_NZ 2
`define DIFD_CFG_CLOSED_LOOP 3
`define DIFD_CFG_W 4

// Function codes
`define DIFD_F_NONE 6'h00
`define DIFD_F_CLEAR 6'h01
`define DIFD_F_COAST_LO 6'h02
`define DIFD_F_CLR_COAST_LO 6'h03
`define DIFD_F_FAST_HALT_LO 6'h04
`define DIFD_F_DC_HALT_LO 6'h05
`define DIFD_F_RAMP_HALT_LO 6'h06
`define DIFD_F_RUN 6'h07
`define DIFD_F_PULSE_RUN 6'h08
`define DIFD_F_DIR_FLIP 6'h09
`define DIFD_F_RUN_FLIP 6'h0a
`define DIFD_F_RUN_CW 6'h0b
`define DIFD_F_RUN_CCW 6'h0c
`define DIFD_F_INCH 6'h0d
`define DIFD_F_HOLD_REF 6'h0e
`define DIFD_F_HOLD_OUT 6'h0f
`define DIFD_F_STEP_UP 6'h10
`define DIFD_F_STEP_DN 6'h11
`define DIFD_F_UNUSED18 6'h12
`define DIFD_F_PCT_BOOST 6'h13
`define DIFD_F_PCT_TRIM 6'h14
`define DIFD_F_ALT_RAMP 6'h15
`define DIFD_F_FIX_SEL0 6'h16
`define DIFD_F_FIX_SEL1 6'h17
`define DIFD_F_FIX_ON 6'h18
`define DIFD_F_UNUSED25 6'h19
`define DIFD_F_ACC_HALT_LO 6'h1a
`define DIFD_F_ACC_RUN_HALT 6'h1b
`define DIFD_F_TRAIN_SET 6'h1c
`define DIFD_F_TRAIN_MEAS 6'h1d
`define DIFD_F_COUNT_IN 6'h1e
`define DIFD_F_PSET_SEL0 6'h1f
`define DIFD_F_PSET_SEL1 6'h20
`define DIFD_F_CLR_RUN 6'h21
`define DIFD_F_QUAD_SET 6'h22
`define DIFD_F_QUAD_MEAS 6'h23
`define DIFD_F_QUAD_COUNT 6'h24

// Code reset values per terminal (parameters 302..306)
`define DIFD_RST_CODE0 6'h07
`define DIFD_RST_CODE1 6'h09
`define DIFD_RST_CODE2 6'h03
`define DIFD_RST_CODE3 6'h0d
`define DIFD_RST_CODE4 6'h00

// Timing
`define DIFD_CLK_KHZ 200000
`define DIFD_MIN_PULSE_MS 14

`endif

// File: shared/difd_pkg.sv
// Types shared by the digital input function decoder.
// Assumes difd_consts.svh is on the include path.
`default_nettype none
`include "difd_consts.svh"

package difd_pkg;
  typedef logic [5:0] difd_code_t;
  typedef logic signed [15:0] difd_adj_t;
endpackage : difd_pkg
`default_nettype wire

// File: src/difd_decoder.sv
// Digital input function decoder: five terminals, per-terminal function codes.
// Assumes one 200 MHz clock, terminals driven by slow external switches.
//
// How it works
// - Each terminal has its own code register
// - Codes 0 to 17 decoded as listed
// - Codes 19-24, 31-33 decoded; 18, 25 refused
// - Terminal-restricted codes refused on other terminals
// - Train codes barred on terminal four with pulse-out
// - Code zero ignores every level and edge
// - Clear alarm on rising edge
// - Low input coasts the motor at once
// - Low coasts; falling edge clears alarm
// - Low brakes with DC when both settings nonzero
// - Low ramps to standstill on selected ramp
// - High runs, low stops
// - Long pulse latches run; ramp halt clears
// - High reverses without run; off in closed loop
// - Run plus reverse on one input; off closed loop
// - Run restricted to one rotation direction
// - Inch to jog frequency unless coast, fast or DC halt active
// - Hold reference; only steps or an adjust-register write change it
// - Hold output frequency; only steps or an adjust-register write change it
// - Qualified step pulses; both high means decrement
// - Boost adds, trim subtracts, both subtract
// - Two bits pick one of four presets
// - Low ramp set one, high ramp set two
`timescale 1ns/1ps
`default_nettype none
`include "difd_consts.svh"

module difd_decoder #(
  parameter int NUM_TERM = 5,
  parameter int CNT_W = 22,
  parameter int MIN_PULSE_CYC = `DIFD_MIN_PULSE_MS * `DIFD_CLK_KHZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Terminals
  input wire logic [NUM_TERM-1:0] term_i,
  // Decoded commands
  output logic alarm_clear_o,
  output logic coast_o,
  output logic fast_halt_o,
  output logic dc_brake_o,
  output logic ramp_halt_o,
  output logic accurate_halt_o,
  output logic run_o,
  output logic reverse_o,
  output logic cw_only_o,
  output logic ccw_only_o,
  output logic inch_o,
  output logic hold_ref_o,
  output logic hold_out_o,
  output logic pct_boost_o,
  output logic pct_trim_o,
  output logic alt_ramp_o,
  output logic [1:0] fixed_sel_o,
  output logic fixed_on_o,
  output logic [1:0] param_set_o,
  output logic [15:0] ref_adj_o,
  output logic [15:0] freq_adj_o
);

  localparam logic [CNT_W-1:0] PULSE_CNT = CNT_W'(MIN_PULSE_CYC);

  // Configuration and code storage
  difd_pkg::difd_code_t code_reg [NUM_TERM];
  logic [`DIFD_CFG_W-1:0] cfg_reg;
  logic [31:0] rdata_reg;
  difd_pkg::difd_adj_t ref_adj_reg;
  difd_pkg::difd_adj_t out_adj_reg;

  // Per-terminal synchroniser and pulse qualification
  logic [NUM_TERM-1:0] sync1_reg;
  logic [NUM_TERM-1:0] sync2_reg;
  logic [NUM_TERM-1:0] lvl_reg;
  logic [NUM_TERM-1:0] rise;
  logic [NUM_TERM-1:0] fall;
  logic [NUM_TERM-1:0] long_hi;
  logic [NUM_TERM-1:0] step_pls;

  // Edges masked until the synchronisers hold real samples
  logic [2:0] prime_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prime_reg <= 3'h0;
    end else begin
      prime_reg <= {prime_reg[1:0], 1'b1};
    end
  end

  // Code legality for a given terminal
  function automatic logic code_ok(input int t, input difd_pkg::difd_code_t c,
                                   input logic pulse_out);
    logic ok;
    ok = 1'b0;
    if (c <= `DIFD_F_STEP_DN) ok = 1'b1;
    else if (c >= `DIFD_F_PCT_BOOST && c <= `DIFD_F_FIX_ON) ok = 1'b1;
    else if (c >= `DIFD_F_PSET_SEL0 && c <= `DIFD_F_CLR_RUN) ok = 1'b1;
    else if (c == `DIFD_F_ACC_HALT_LO) ok = (t != 2);
    else if (c == `DIFD_F_ACC_RUN_HALT) ok = (t < 2);
    else if (c == `DIFD_F_TRAIN_SET || c == `DIFD_F_TRAIN_MEAS)
      ok = (t == 4) || (t == 3 && !pulse_out);
    else if (c == `DIFD_F_QUAD_SET || c == `DIFD_F_QUAD_MEAS) ok = (t >= 3);
    else if (c == `DIFD_F_COUNT_IN || c == `DIFD_F_QUAD_COUNT) ok = (t == 4);
    return ok;
  endfunction : code_ok

  // Input synchronisation and qualification per terminal
  genvar g;
  generate
    for (g = 0; g < NUM_TERM; g++) begin : g_term
      logic [CNT_W-1:0] cnt_reg;
      logic armed_reg;
      logic gap_reg;
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
          lvl_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= term_i[g];
          sync2_reg[g] <= sync1_reg[g];
          lvl_reg[g] <= sync2_reg[g];
        end
      end
      assign rise[g] = prime_reg[2] & sync2_reg[g] & ~lvl_reg[g];
      assign fall[g] = prime_reg[2] & ~sync2_reg[g] & lvl_reg[g];
      // Time the present level since its last change
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          cnt_reg <= '0;
        end else if (rise[g] || fall[g]) begin
          cnt_reg <= '0;
        end else if (cnt_reg != PULSE_CNT) begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
      assign long_hi[g] = lvl_reg[g] && !rise[g] && !fall[g] && cnt_reg == PULSE_CNT - 1'b1;
      // Step pulse: qualified high phase, then qualified low phase
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          armed_reg <= 1'b0;
          gap_reg <= 1'b0;
        end else begin
          if (long_hi[g]) armed_reg <= 1'b1;
          else if (gap_reg || rise[g]) armed_reg <= 1'b0;
          gap_reg <= armed_reg && fall[g] ? 1'b1 : (rise[g] || step_pls[g]) ? 1'b0 : gap_reg;
        end
      end
      assign step_pls[g] = gap_reg && !lvl_reg[g] && !fall[g] && !rise[g]
                           && cnt_reg == PULSE_CNT - 1'b1;
    end
  endgenerate

  // Decode of terminal levels into commands
  logic clr_any, coast_any, fast_any, dc_any, rhalt_any, acc_any;
  logic run_lvl, latch_set, flip_any, runflip_any, cw_any, ccw_any, inch_any;
  logic href_any, hout_any, up_any, dn_any, dn_lvl, boost_any, trim_any;
  logic ramp2_any, fs0_any, fs1_any, fon_any, ps0_any, ps1_any, clrrun_any;
  logic accrun_any;

  always_comb begin
    clr_any = 1'b0;
    coast_any = 1'b0;
    fast_any = 1'b0;
    dc_any = 1'b0;
    rhalt_any = 1'b0;
    acc_any = 1'b0;
    run_lvl = 1'b0;
    latch_set = 1'b0;
    flip_any = 1'b0;
    runflip_any = 1'b0;
    cw_any = 1'b0;
    ccw_any = 1'b0;
    inch_any = 1'b0;
    href_any = 1'b0;
    hout_any = 1'b0;
    up_any = 1'b0;
    dn_any = 1'b0;
    dn_lvl = 1'b0;
    boost_any = 1'b0;
    trim_any = 1'b0;
    ramp2_any = 1'b0;
    fs0_any = 1'b0;
    fs1_any = 1'b0;
    fon_any = 1'b0;
    ps0_any = 1'b0;
    ps1_any = 1'b0;
    clrrun_any = 1'b0;
    accrun_any = 1'b0;
    for (int t = 0; t < NUM_TERM; t++) begin
      case (code_reg[t])
        `DIFD_F_CLEAR: clr_any |= rise[t];
        `DIFD_F_COAST_LO: coast_any |= ~lvl_reg[t];
        `DIFD_F_CLR_COAST_LO: begin
          coast_any |= ~lvl_reg[t];
          clr_any |= fall[t];
        end
        `DIFD_F_FAST_HALT_LO: fast_any |= ~lvl_reg[t];
        `DIFD_F_DC_HALT_LO: dc_any |= ~lvl_reg[t];
        `DIFD_F_RAMP_HALT_LO: rhalt_any |= ~lvl_reg[t];
        `DIFD_F_RUN: run_lvl |= lvl_reg[t];
        `DIFD_F_PULSE_RUN: latch_set |= long_hi[t];
        `DIFD_F_DIR_FLIP: flip_any |= lvl_reg[t];
        `DIFD_F_RUN_FLIP: runflip_any |= lvl_reg[t];
        `DIFD_F_RUN_CW: cw_any |= lvl_reg[t];
        `DIFD_F_RUN_CCW: ccw_any |= lvl_reg[t];
        `DIFD_F_INCH: inch_any |= lvl_reg[t];
        `DIFD_F_HOLD_REF: href_any |= lvl_reg[t];
        `DIFD_F_HOLD_OUT: hout_any |= lvl_reg[t];
        `DIFD_F_STEP_UP: up_any |= step_pls[t];
        `DIFD_F_STEP_DN: begin
          dn_any |= step_pls[t];
          dn_lvl |= lvl_reg[t];
        end
        `DIFD_F_PCT_BOOST: boost_any |= lvl_reg[t];
        `DIFD_F_PCT_TRIM: trim_any |= lvl_reg[t];
        `DIFD_F_ALT_RAMP: ramp2_any |= lvl_reg[t];
        `DIFD_F_FIX_SEL0: fs0_any |= lvl_reg[t];
        `DIFD_F_FIX_SEL1: fs1_any |= lvl_reg[t];
        `DIFD_F_FIX_ON: fon_any |= lvl_reg[t];
        `DIFD_F_ACC_HALT_LO: acc_any |= ~lvl_reg[t];
        `DIFD_F_ACC_RUN_HALT: accrun_any |= lvl_reg[t];
        `DIFD_F_PSET_SEL0: ps0_any |= lvl_reg[t];
        `DIFD_F_PSET_SEL1: ps1_any |= lvl_reg[t];
        `DIFD_F_CLR_RUN: begin
          clr_any |= rise[t];
          clrrun_any |= lvl_reg[t];
        end
        default: ;
      endcase
    end
  end

  // Combined command state
  logic dc_ok, closed, stop_any, latch_reg, run_next, rev_next, step_dn, step_up;
  assign dc_ok = cfg_reg[`DIFD_CFG_DC_TIME_NZ] & cfg_reg[`DIFD_CFG_DC_VOLT_NZ];
  assign closed = cfg_reg[`DIFD_CFG_CLOSED_LOOP];
  assign stop_any = coast_any | fast_any | (dc_any & dc_ok) | rhalt_any | acc_any;
  assign run_next = (run_lvl | latch_reg | (runflip_any & ~closed) | cw_any | ccw_any
                     | clrrun_any | accrun_any) & ~stop_any;
  assign rev_next = ((flip_any | runflip_any) & ~closed & ~cw_any) | ccw_any;
  assign step_dn = dn_any | (up_any & dn_lvl);
  assign step_up = up_any & ~dn_lvl & ~dn_any;

  // Run latch for pulse start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_reg <= 1'b0;
    end else if (stop_any) begin
      latch_reg <= 1'b0;
    end else if (latch_set) begin
      latch_reg <= 1'b1;
    end
  end

  // Command outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alarm_clear_o <= 1'b0;
      coast_o <= 1'b0;
      fast_halt_o <= 1'b0;
      dc_brake_o <= 1'b0;
      ramp_halt_o <= 1'b0;
      accurate_halt_o <= 1'b0;
      run_o <= 1'b0;
      reverse_o <= 1'b0;
      cw_only_o <= 1'b0;
      ccw_only_o <= 1'b0;
      inch_o <= 1'b0;
      hold_ref_o <= 1'b0;
      hold_out_o <= 1'b0;
      pct_boost_o <= 1'b0;
      pct_trim_o <= 1'b0;
      alt_ramp_o <= 1'b0;
      fixed_sel_o <= 2'h0;
      fixed_on_o <= 1'b0;
      param_set_o <= 2'h0;
    end else begin
      alarm_clear_o <= clr_any;
      coast_o <= coast_any;
      fast_halt_o <= fast_any;
      dc_brake_o <= dc_any & dc_ok;
      ramp_halt_o <= rhalt_any | acc_any;
      accurate_halt_o <= acc_any;
      run_o <= run_next;
      reverse_o <= rev_next;
      cw_only_o <= cw_any;
      ccw_only_o <= ccw_any;
      inch_o <= inch_any & ~coast_any & ~fast_any & ~(dc_any & dc_ok);
      hold_ref_o <= href_any;
      hold_out_o <= hout_any;
      pct_boost_o <= boost_any & ~trim_any;
      pct_trim_o <= trim_any;
      alt_ramp_o <= ramp2_any;
      fixed_sel_o <= {fs1_any, fs0_any};
      fixed_on_o <= fon_any;
      param_set_o <= {ps1_any, ps0_any};
    end
  end

  // Step accumulators, kept through stops; software may restore them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_adj_reg <= '0;
      out_adj_reg <= '0;
    end else if (wr_i && addr_i == `DIFD_OFS_ADJ) begin
      ref_adj_reg <= wdata_i[15:0];
      out_adj_reg <= wdata_i[31:16];
    end else begin
      if (href_any && step_up) ref_adj_reg <= ref_adj_reg + 16'sh0001;
      else if (href_any && step_dn) ref_adj_reg <= ref_adj_reg - 16'sh0001;
      if (hout_any && step_up) out_adj_reg <= out_adj_reg + 16'sh0001;
      else if (hout_any && step_dn) out_adj_reg <= out_adj_reg - 16'sh0001;
    end
  end
  assign ref_adj_o = ref_adj_reg;
  assign freq_adj_o = out_adj_reg;

  // Code and config registers; illegal codes leave the old value
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      code_reg[0] <= `DIFD_RST_CODE0;
      code_reg[1] <= `DIFD_RST_CODE1;
      code_reg[2] <= `DIFD_RST_CODE2;
      code_reg[3] <= `DIFD_RST_CODE3;
      code_reg[4] <= `DIFD_RST_CODE4;
      cfg_reg <= '0;
    end else if (wr_i) begin
      for (int t = 0; t < NUM_TERM; t++) begin
        if (addr_i == `DIFD_OFS_CODE0 + 8'(4 * t)
            && code_ok(t, wdata_i[5:0], cfg_reg[`DIFD_CFG_PULSE_OUT])) begin
          code_reg[t] <= wdata_i[5:0];
        end
      end
      if (addr_i == `DIFD_OFS_CFG) begin
        // Pulse output refused while terminal four holds a train code
        cfg_reg[`DIFD_CFG_W-1:1] <= wdata_i[`DIFD_CFG_W-1:1];
        if (!(wdata_i[`DIFD_CFG_PULSE_OUT] && (code_reg[3] == `DIFD_F_TRAIN_SET
            || code_reg[3] == `DIFD_F_TRAIN_MEAS))) begin
          cfg_reg[`DIFD_CFG_PULSE_OUT] <= wdata_i[`DIFD_CFG_PULSE_OUT];
        end
      end
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else if (rd_i) begin
      rdata_reg <= '0;
      for (int t = 0; t < NUM_TERM; t++) begin
        if (addr_i == `DIFD_OFS_CODE0 + 8'(4 * t)) rdata_reg <= {26'h0, code_reg[t]};
      end
      if (addr_i == `DIFD_OFS_CFG) rdata_reg <= {28'h0, cfg_reg};
      if (addr_i == `DIFD_OFS_STAT) begin
        rdata_reg <= {9'h0, lvl_reg, latch_reg, param_set_o, fixed_on_o, fixed_sel_o,
                      alt_ramp_o, pct_trim_o, pct_boost_o, hold_out_o, hold_ref_o, inch_o,
                      reverse_o, run_o, ramp_halt_o, dc_brake_o, fast_halt_o, coast_o};
      end
      if (addr_i == `DIFD_OFS_ADJ) rdata_reg <= {out_adj_reg, ref_adj_reg};
    end else begin
      rdata_reg <= '0;
    end
  end
  assign rdata_o = rdata_reg;

endmodule : difd_decoder
`default_nettype wire

// File: tb/difd_decoder_properties.sv
// Checker for the decoder's command and register outputs.
// Bound to difd_decoder; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module difd_decoder_chk (
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Commands
  input wire logic alarm_clear_o,
  input wire logic coast_o,
  input wire logic fast_halt_o,
  input wire logic dc_brake_o,
  input wire logic ramp_halt_o,
  input wire logic run_o,
  input wire logic reverse_o,
  input wire logic cw_only_o,
  input wire logic ccw_only_o,
  input wire logic inch_o,
  input wire logic hold_ref_o,
  input wire logic hold_out_o,
  input wire logic pct_boost_o,
  input wire logic pct_trim_o,
  input wire logic [15:0] ref_adj_o,
  input wire logic [15:0] freq_adj_o
);
  logic held;
  assign held = hold_ref_o | hold_out_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read slot");
  a_clear_pulse: assert property (alarm_clear_o |=> !alarm_clear_o)
    else $error("alarm clear longer than one cycle");
  a_run_no_stop: assert property (run_o |-> !(coast_o || fast_halt_o || dc_brake_o || ramp_halt_o))
    else $error("run during stop");
  a_inch_masked: assert property (inch_o |-> !(coast_o || fast_halt_o || dc_brake_o))
    else $error("inch during stop");
  a_cw_forward: assert property (cw_only_o && !ccw_only_o |-> !reverse_o)
    else $error("reverse under clockwise only");
  a_ccw_reverse: assert property (ccw_only_o |-> reverse_o)
    else $error("no reverse under counter-clockwise only");
  a_trim_wins: assert property (pct_boost_o |-> !pct_trim_o)
    else $error("boost and trim together");
  a_ref_frozen: assert property (!$past(wr_i) && !held && !$past(held) && !$past(held, 2)
    |-> $stable(ref_adj_o)) else $error("reference moved without hold");
  a_freq_frozen: assert property (!$past(wr_i) && !held && !$past(held) && !$past(held, 2)
    |-> $stable(freq_adj_o)) else $error("frequency moved without hold");
  a_step_size: assert property (!$past(wr_i) && !$stable(ref_adj_o)
    |-> (ref_adj_o - $past(ref_adj_o)) inside {16'h0001, 16'hffff}) else $error("bad step");
endmodule : difd_decoder_chk
bind difd_decoder difd_decoder_chk u_chk (.clk_i, .rst_i, .wr_i, .rd_i, .rdata_o,
  .alarm_clear_o, .coast_o, .fast_halt_o, .dc_brake_o, .ramp_halt_o, .run_o, .reverse_o,
  .cw_only_o, .ccw_only_o, .inch_o, .hold_ref_o, .hold_out_o, .pct_boost_o, .pct_trim_o,
  .ref_adj_o, .freq_adj_o);
`default_nettype wire

// File: tb/difd_term_drv.sv
// Switch model for the five terminals: static levels plus timed pulses.
// Driven by the bench right after rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module difd_term_drv (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Requests
  input wire logic [4:0] lvl_i,
  input wire logic go_i,
  input wire logic [2:0] idx_i,
  input wire logic [7:0] hi_i,
  input wire logic [7:0] lo_i,
  // Terminals
  output logic [4:0] term_o,
  output logic busy_o
);
  logic [8:0] cnt_reg;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 9'h000;
    end else if (go_i && !busy_o) begin
      cnt_reg <= {1'b0, hi_i} + {1'b0, lo_i};
    end else if (busy_o) begin
      cnt_reg <= cnt_reg - 9'h001;
    end
  end
  assign busy_o = cnt_reg != 9'h000;
  always_comb begin
    term_o = lvl_i;
    if (busy_o) begin
      term_o[idx_i] = cnt_reg > {1'b0, lo_i};
    end
  end
endmodule : difd_term_drv
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the input decoder.
// Terminals come from the switch model; registers from bus tasks.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int MINP = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [4:0] lvl = 5'h05;
  logic go = 1'b0;
  logic [2:0] pidx = 3'h0;
  logic [7:0] hi = 8'h00;
  logic [7:0] lo = 8'h00;
  logic [4:0] term;
  logic busy;
  logic [31:0] rdata;
  logic aclr, coast, fast, dc, ramp, run, rev, cw, ccw, inch, href, hout, boost, trim, alt, fon;
  logic [1:0] fsel;
  logic [15:0] radj, fadj;
  logic acc;
  logic [1:0] pset;
  logic [14:0] outs;
  int errors = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h56;
  logic [5:0] cur [5] = '{6'h07, 6'h09, 6'h03, 6'h0d, 6'h00};
  logic [9:0] tab [12] = '{10'h012, 10'h059, 10'h09a, 10'h09b, 10'h01c, 10'h0de,
    10'h0a2, 10'h125, 10'h324, 10'h25b, 10'h21a, 10'h2dc};
  logic [5:0] lc [13] = '{6'h02, 6'h04, 6'h05, 6'h06, 6'h0d, 6'h0e, 6'h0f, 6'h13, 6'h14,
    6'h15, 6'h18, 6'h0b, 6'h0c};
  int lb [13] = '{0, 1, 2, 3, 6, 7, 8, 9, 10, 11, 12, 13, 14};
  assign outs = {ccw, cw, fon, alt, trim, boost, hout, href, inch, rev, run, ramp, dc, fast, coast};
  difd_term_drv u_sw (.clk_i(clk), .rst_i(rst), .lvl_i(lvl), .go_i(go), .idx_i(pidx),
    .hi_i(hi), .lo_i(lo), .term_o(term), .busy_o(busy));
  difd_decoder #(.MIN_PULSE_CYC(MINP)) dut (.clk_i(clk), .rst_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .term_i(term),
    .alarm_clear_o(aclr), .coast_o(coast), .fast_halt_o(fast), .dc_brake_o(dc),
    .ramp_halt_o(ramp), .accurate_halt_o(acc), .run_o(run), .reverse_o(rev), .cw_only_o(cw),
    .ccw_only_o(ccw), .inch_o(inch), .hold_ref_o(href), .hold_out_o(hout),
    .pct_boost_o(boost), .pct_trim_o(trim), .alt_ramp_o(alt), .fixed_sel_o(fsel),
    .fixed_on_o(fon), .param_set_o(pset), .ref_adj_o(radj), .freq_adj_o(fadj));
  always #2.5 clk = ~clk;
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task summarize();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk) wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) rd <= 1'b1;
    addr <= a;
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) d = rdata;
  endtask : rreg
  task wcode(input int i, input logic [5:0] c);
    wreg(8'(i * 4), {26'h0, c});
  endtask : wcode
  task setl(input int i, input logic v);
    @(posedge clk) lvl[i] <= v;
  endtask : setl
  task pulse(input int i, input int h, input int l);
    @(posedge clk) go <= 1'b1;
    pidx <= 3'(i);
    hi <= 8'(h);
    lo <= 8'(l);
    @(posedge clk) go <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 600 && busy; k++) @(posedge clk);
  endtask : pulse
  task clr_count(output int n);
    n = 0;
    repeat (8) @(negedge clk) n += aclr;
  endtask : clr_count
  initial begin
    #100us;
    errors++;
    summarize();
  end
  initial begin
    logic [31:0] d;
    logic [31:0] w;
    logic b;
    int n;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rreg(8'(i * 4), d);
      chk(d, {26'h0, cur[i]});
    end
    rreg(8'h40, d);
    chk(d, 32'h0);
    foreach (tab[k]) begin
      wcode(tab[k][8:6], tab[k][5:0]);
      if (tab[k][9]) cur[tab[k][8:6]] = tab[k][5:0];
      rreg(8'(tab[k][8:6] * 4), d);
      chk(d, {26'h0, cur[tab[k][8:6]]});
    end
    wreg(8'h14, 32'h1);
    rreg(8'h14, d);
    chk(d, 32'h0);
    wcode(3, 6'h00);
    wreg(8'h14, 32'h1);
    wcode(3, 6'h1d);
    rreg(8'h0c, d);
    chk(d, 32'h0);
    $display("test code table done");
    wcode(0, 6'h07);
    wcode(1, 6'h00);
    wreg(8'h14, 32'h6);
    cyc(4);
    chk(run, 1'b1);
    setl(0, 1'b0);
    cyc(4);
    chk(run, 1'b0);
    foreach (lc[k]) begin
      wcode(4, lc[k]);
      b = 1'(rnd());
      for (int j = 0; j < 2; j++) begin
        setl(4, b ^ j[0]);
        cyc(4);
        chk(outs[lb[k]], (b ^ j[0]) ^ (k < 4));
      end
    end
    wcode(4, 6'h00);
    cyc(2);
    d = outs;
    setl(4, ~lvl[4]);
    cyc(4);
    chk(outs, d);
    wreg(8'h14, 32'h0);
    wcode(4, 6'h05);
    setl(4, 1'b0);
    cyc(4);
    chk(dc, 1'b0);
    for (int c = 1; c < 4; c += 2) begin
      wcode(4, 6'(c));
      setl(4, 1'b1);
      clr_count(n);
      chk(n, c == 1);
      setl(4, 1'b0);
      clr_count(n);
      chk(n, c == 3);
    end
    chk(coast, 1'b1);
    $display("test levels and edges done");
    wcode(0, 6'h00);
    setl(3, 1'b1);
    wcode(3, 6'h06);
    wcode(4, 6'h08);
    pulse(4, MINP / 2, 2);
    cyc(6);
    chk(run, 1'b0);
    pulse(4, MINP + 5, 2);
    cyc(6);
    chk(run, 1'b1);
    setl(3, 1'b0);
    cyc(3);
    setl(3, 1'b1);
    cyc(6);
    chk(run, 1'b0);
    $display("test latched run done");
    setl(3, 1'b0);
    wcode(4, 6'h10);
    wcode(3, 6'h11);
    wcode(1, 6'h0e);
    setl(1, 1'b1);
    w = rnd();
    wreg(8'h1c, w);
    cyc(2);
    chk(radj, w[15:0]);
    pulse(4, MINP + 5, MINP + 5);
    cyc(6);
    chk(radj, 16'(w[15:0] + 16'h1));
    setl(3, 1'b1);
    pulse(4, MINP + 5, MINP + 5);
    cyc(6);
    chk(radj, w[15:0]);
    chk(fadj, w[31:16]);
    $display("test steps done");
    wcode(1, 6'h16);
    wcode(3, 6'h17);
    for (int v = 0; v < 4; v++) begin
      @(posedge clk) lvl[1] <= v[0];
      lvl[3] <= v[1];
      cyc(4);
      chk(fsel, v);
    end
    $display("test presets done");
    wcode(3, 6'h00);
    wcode(1, 6'h09);
    cyc(2);
    chk({run, rev}, 2'b01);
    wreg(8'h14, 32'h8);
    cyc(2);
    chk(rev, 1'b0);
    wcode(1, 6'h00);
    wcode(3, 6'h0a);
    cyc(2);
    chk({run, rev}, 2'b00);
    wreg(8'h14, 32'h0);
    cyc(2);
    chk({run, rev}, 2'b11);
    $display("test direction done");
    wcode(3, 6'h14);
    wcode(1, 6'h13);
    cyc(2);
    chk({boost, trim}, 2'b01);
    setl(3, 1'b0);
    cyc(4);
    chk({boost, trim}, 2'b10);
    wcode(3, 6'h00);
    wcode(1, 6'h0f);
    pulse(4, MINP + 5, MINP + 5);
    cyc(6);
    chk(fadj, 16'(w[31:16] + 16'h1));
    chk(radj, w[15:0]);
    setl(3, 1'b1);
    wcode(3, 6'h1f);
    wcode(1, 6'h1a);
    setl(1, 1'b0);
    cyc(4);
    chk({acc, ramp, pset}, 4'hd);
    wcode(3, 6'h0d);
    wcode(1, 6'h02);
    cyc(2);
    chk({inch, coast}, 2'b01);
    setl(1, 1'b1);
    cyc(4);
    chk({inch, coast}, 2'b10);
    $display("test remaining functions done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
